/* core/pfhc_ctrl.sv */
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Host writes reset command when timeout flag high or in ident mode.
// - Protect addressing uses A6, A1, A0 pattern with sector on upper bits.
// - Ident mode entered by a written command sequence, no high voltage.
// - Command cycles drive write enable and chip select low, OE high.
// - Protect or unprotect only with reset pin at elevated voltage.
// - Every group must be protected before any chip-unprotect cycle.
module pfhc_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash pins
    output logic [20:0] flash_addr,
    output logic [15:0] flash_dq_o,
    output logic [15:0] flash_dq_oe,
    input wire logic [15:0] flash_dq_i,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic flash_hv_reset_en,
    output logic flash_byte_n,
    output logic flash_wp_n
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pfhc_pkg::pfhc_state_type st;
        logic [2:0] op;
        logic [1:0] step;
        logic [7:0] cnt;
        logic [4:0] ctrl;
        logic [20:0] addr;
        logic alsb;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [23:0] pmask;
        logic id_mode;
        logic need_rst;
        logic refused;
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_pin_n;
        logic [20:0] a_o;
        logic [15:0] dq_o;
        logic [15:0] dq_oe;
        logic [31:0] prdata;
    } pfhc_regs_type;

    pfhc_regs_type r_q;
    pfhc_regs_type r_d;

    // Group index of a sector address, top or bottom boot map
    function automatic logic [4:0] pfhc_group(input logic [8:0] sa, input logic bottom);
        logic [4:0] g;
        g = 5'h00;
        if (!bottom) begin
            if (sa[8:5] != 4'hF) begin
                g = {1'b0, sa[8:5]};
            end else if (sa[4:3] != 2'h3) begin
                g = 5'h0F;
            end else begin
                g = 5'h10 + {2'h0, sa[2:0]};
            end
        end else begin
            if (sa[8:5] != 4'h0) begin
                g = 5'h08 + {1'b0, sa[8:5]};
            end else if (sa[4:3] != 2'h0) begin
                g = 5'h08;
            end else begin
                g = {2'h0, sa[2:0]};
            end
        end
        return g;
    endfunction

    // Zero wait states
    logic apb_setup;
    logic apb_wr;
    logic busy;
    logic mapped;
    logic cmd_ok;
    logic [2:0] new_op;
    logic [20:0] cyc_addr;
    logic [15:0] cyc_data;
    logic last_step;
    logic prot_op;
    logic [20:0] pat_addr;

    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pwrite;
    assign busy = (r_q.st != pfhc_pkg::ST_IDLE);
    assign mapped = (paddr <= pfhc_pkg::REG_PMASK) && (paddr[1:0] == 2'h0);
    assign new_op = pwdata[2:0];
    assign prot_op = (r_q.op == pfhc_pkg::OP_PROTECT) || (r_q.op == pfhc_pkg::OP_UNPROTECT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Order is legal when idle with a defined op code, HV present for protect ops, and all groups
    // protected before a chip unprotect; anything else is flagged refused
    always_comb begin
        cmd_ok = !busy && (new_op <= pfhc_pkg::OP_UNPROTECT);
        if ((new_op == pfhc_pkg::OP_PROTECT) || (new_op == pfhc_pkg::OP_UNPROTECT)) begin
            cmd_ok = cmd_ok && r_q.ctrl[pfhc_pkg::CTRL_HV];
        end
        if (new_op == pfhc_pkg::OP_UNPROTECT) begin
            cmd_ok = cmd_ok && (r_q.pmask == pfhc_pkg::PMASK_ALL);
        end
    end

    // Protect cycle address: sector bits kept, A6/A1/A0 pattern forced
    always_comb begin
        pat_addr = r_q.addr;
        pat_addr[pfhc_pkg::PAT_A6] = (r_q.op == pfhc_pkg::OP_UNPROTECT);
        pat_addr[pfhc_pkg::PAT_A1] = 1'b1;
        pat_addr[0] = 1'b0;
    end

    // Address and data of the current command cycle
    always_comb begin
        cyc_addr = r_q.addr;
        cyc_data = r_q.wdata;
        last_step = 1'b1;
        case (r_q.op)
            pfhc_pkg::OP_CMD_RESET: begin
                cyc_data = pfhc_pkg::RESET_DATA;
            end
            pfhc_pkg::OP_IDENT: begin
                last_step = (r_q.step == 2'h2);
                case (r_q.step)
                    2'h0: begin
                        cyc_addr = pfhc_pkg::UNLOCK1_ADDR;
                        cyc_data = pfhc_pkg::UNLOCK1_DATA;
                    end
                    2'h1: begin
                        cyc_addr = pfhc_pkg::UNLOCK2_ADDR;
                        cyc_data = pfhc_pkg::UNLOCK2_DATA;
                    end
                    default: begin
                        cyc_addr = pfhc_pkg::UNLOCK1_ADDR;
                        cyc_data = pfhc_pkg::IDENT_DATA;
                    end
                endcase
            end
            pfhc_pkg::OP_PROTECT, pfhc_pkg::OP_UNPROTECT: begin
                cyc_addr = pat_addr;
            end
            default: begin
                cyc_addr = r_q.addr;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.cnt = r_q.cnt + 8'h01;
        // First stage feeds only the second
        r_d.s1 = flash_dq_i;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;

        // Read data taken in setup phase
        if (apb_setup) begin
            case (paddr)
                pfhc_pkg::REG_CTRL: r_d.prdata = {27'h0, r_q.ctrl};
                pfhc_pkg::REG_ADDR: r_d.prdata = {r_q.alsb, 10'h0, r_q.addr};
                pfhc_pkg::REG_WDATA: r_d.prdata = {16'h0, r_q.wdata};
                pfhc_pkg::REG_CMD: r_d.prdata = {29'h0, r_q.op};
                pfhc_pkg::REG_STATUS: r_d.prdata = {28'h0, r_q.refused, r_q.need_rst,
                    r_q.id_mode, busy};
                pfhc_pkg::REG_RDATA: r_d.prdata = {16'h0, r_q.rdata};
                pfhc_pkg::REG_PMASK: r_d.prdata = {8'h0, r_q.pmask};
                default: r_d.prdata = 32'h0;
            endcase
        end

        // Register writes; status refused bit is write-one-to-clear
        if (apb_wr) begin
            case (paddr)
                pfhc_pkg::REG_CTRL: r_d.ctrl = pwdata[4:0];
                pfhc_pkg::REG_ADDR: begin
                    r_d.addr = pwdata[20:0];
                    r_d.alsb = pwdata[pfhc_pkg::ADDR_LSB_BIT];
                end
                pfhc_pkg::REG_WDATA: r_d.wdata = pwdata[15:0];
                pfhc_pkg::REG_STATUS: begin
                    if (pwdata[pfhc_pkg::STAT_REFUSED]) begin
                        r_d.refused = 1'b0;
                    end
                end
                pfhc_pkg::REG_CMD: begin
                    if (cmd_ok) begin
                        r_d.op = new_op;
                        r_d.step = 2'h0;
                        r_d.cnt = 8'h00;
                        r_d.ce_n = 1'b0;
                        r_d.a_o = r_q.addr;
                        if (new_op == pfhc_pkg::OP_READ) begin
                            r_d.st = pfhc_pkg::ST_READ;
                            r_d.oe_n = 1'b0;
                        end else if (new_op == pfhc_pkg::OP_HW_RESET) begin
                            r_d.st = pfhc_pkg::ST_RST_LOW;
                            r_d.ce_n = 1'b1;
                            r_d.rst_pin_n = 1'b0;
                        end else begin
                            r_d.st = pfhc_pkg::ST_WR_SET;
                        end
                    end
                end
                default: begin
                    r_d.ctrl = r_q.ctrl;
                end
            endcase
        end

        // Data lines: byte mode leaves 14..8 to the device, top line is A-1
        r_d.dq_oe = 16'h0000;
        r_d.dq_o = 16'h0000;
        if (r_d.ctrl[pfhc_pkg::CTRL_BYTE]) begin
            r_d.dq_oe[15] = !r_d.ce_n;
            r_d.dq_o[15] = r_d.alsb;
        end

        case (r_q.st)
            pfhc_pkg::ST_IDLE: begin
                r_d.cnt = 8'h00;
            end
            // Wait access time plus synchroniser, then take a stable word
            pfhc_pkg::ST_READ: begin
                if ((r_q.cnt >= pfhc_pkg::RD_WAIT_CYC) && (r_q.s2[7:0] == r_q.s3[7:0])
                    && (r_q.ctrl[pfhc_pkg::CTRL_BYTE] || (r_q.s2 == r_q.s3))) begin
                    r_d.rdata = r_q.s3;
                    if (r_q.ctrl[pfhc_pkg::CTRL_BYTE]) begin
                        r_d.rdata[15:8] = 8'h00;
                    end
                    r_d.oe_n = 1'b1;
                    r_d.cnt = 8'h00;
                    if (r_q.s3[pfhc_pkg::TIMEOUT_BIT] || r_q.id_mode) begin
                        r_d.need_rst = 1'b1;
                    end
                    if ((r_q.s3[pfhc_pkg::TIMEOUT_BIT] || r_q.id_mode)
                        && r_q.ctrl[pfhc_pkg::CTRL_AUTO_RST]) begin
                        r_d.op = pfhc_pkg::OP_CMD_RESET;
                        r_d.step = 2'h0;
                        r_d.st = pfhc_pkg::ST_WR_SET;
                    end else begin
                        r_d.ce_n = 1'b1;
                        r_d.st = pfhc_pkg::ST_IDLE;
                    end
                end
            end
            // Address and data settle before the write strobe falls
            pfhc_pkg::ST_WR_SET: begin
                r_d.oe_n = 1'b1;
                r_d.a_o = cyc_addr;
                if (r_q.cnt + 8'h01 >= pfhc_pkg::SETUP_CYC) begin
                    r_d.cnt = 8'h00;
                    r_d.we_n = 1'b0;
                    r_d.st = pfhc_pkg::ST_WR_LOW;
                end
            end
            pfhc_pkg::ST_WR_LOW: begin
                if (r_q.cnt + 8'h01 >= pfhc_pkg::WP_CYC) begin
                    r_d.cnt = 8'h00;
                    r_d.we_n = 1'b1;
                    r_d.ce_n = 1'b1;
                    r_d.st = pfhc_pkg::ST_WR_HIGH;
                end
            end
            pfhc_pkg::ST_WR_HIGH: begin
                if (r_q.cnt + 8'h01 >= pfhc_pkg::WPH_CYC) begin
                    r_d.cnt = 8'h00;
                    if (last_step) begin
                        r_d.st = pfhc_pkg::ST_IDLE;
                        if (r_q.op == pfhc_pkg::OP_IDENT) begin
                            r_d.id_mode = 1'b1;
                        end
                        if (r_q.op == pfhc_pkg::OP_CMD_RESET) begin
                            r_d.id_mode = 1'b0;
                            r_d.need_rst = 1'b0;
                        end
                        if (r_q.op == pfhc_pkg::OP_PROTECT) begin
                            r_d.pmask[pfhc_group(r_q.addr[20:12],
                                r_q.ctrl[pfhc_pkg::CTRL_BOTTOM])] = 1'b1;
                        end
                        if (r_q.op == pfhc_pkg::OP_UNPROTECT) begin
                            r_d.pmask = pfhc_pkg::PMASK_RESET;
                        end
                    end else begin
                        r_d.step = r_q.step + 2'h1;
                        r_d.ce_n = 1'b0;
                        r_d.st = pfhc_pkg::ST_WR_SET;
                    end
                end
            end
            pfhc_pkg::ST_RST_LOW: begin
                if (r_q.cnt + 8'h01 >= pfhc_pkg::RP_CYC) begin
                    r_d.cnt = 8'h00;
                    r_d.rst_pin_n = 1'b1;
                    r_d.st = pfhc_pkg::ST_RST_REC;
                end
            end
            pfhc_pkg::ST_RST_REC: begin
                if (r_q.cnt + 8'h01 >= pfhc_pkg::RH_CYC) begin
                    r_d.id_mode = 1'b0;
                    r_d.need_rst = 1'b0;
                    r_d.st = pfhc_pkg::ST_IDLE;
                end
            end
            default: begin
                r_d.st = pfhc_pkg::ST_IDLE;
            end
        endcase

        // Drive write data only while a write cycle holds the bus
        if ((r_d.st == pfhc_pkg::ST_WR_SET) || (r_d.st == pfhc_pkg::ST_WR_LOW)) begin
            if (r_d.ctrl[pfhc_pkg::CTRL_BYTE]) begin
                r_d.dq_oe[7:0] = 8'hFF;
                r_d.dq_o[7:0] = cyc_data[7:0];
                r_d.dq_o[15] = 1'b0; // Command cycles use A-1 low
            end else begin
                r_d.dq_oe = 16'hFFFF;
                r_d.dq_o = cyc_data;
            end
        end

        // Refused command: set wins over the same-cycle clear
        if (apb_wr && (paddr == pfhc_pkg::REG_CMD) && !cmd_ok) begin
            r_d.refused = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.st <= pfhc_pkg::ST_IDLE;
            r_q.ctrl <= pfhc_pkg::CTRL_RESET;
            r_q.ce_n <= 1'b1;
            r_q.oe_n <= 1'b1;
            r_q.we_n <= 1'b1;
            r_q.rst_pin_n <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // Pin outputs, all from flops
    assign prdata = r_q.prdata;
    assign flash_addr = r_q.a_o;
    assign flash_dq_o = r_q.dq_o;
    assign flash_dq_oe = r_q.dq_oe;
    assign flash_ce_n = r_q.ce_n;
    assign flash_oe_n = r_q.oe_n;
    assign flash_we_n = r_q.we_n;
    assign flash_reset_n = r_q.rst_pin_n;
    assign flash_hv_reset_en = r_q.ctrl[pfhc_pkg::CTRL_HV];
    assign flash_byte_n = !r_q.ctrl[pfhc_pkg::CTRL_BYTE];
    assign flash_wp_n = r_q.ctrl[pfhc_pkg::CTRL_WP_N];

endmodule // pfhc_ctrl

/* dv/pfhc_ctrl_monitor.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Pin checker
// ------------------------------------------------------------
module pfhc_ctrl_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Flash pins
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic flash_byte_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Reset pin low time
    logic [7:0] rlow_q;
    always_ff @(posedge clk_sys) begin
        rlow_q <= (!rst_n || flash_reset_n) ? 8'h00 : rlow_q + 8'h01;
    end
    property p_we_frame; !flash_we_n |-> !flash_ce_n && flash_oe_n; endproperty
    a_we_frame: assert property (p_we_frame) else $error("write strobe outside frame");
    property p_we_setup; $fell(flash_we_n) |-> $past(!flash_ce_n && flash_we_n); endproperty
    a_we_setup: assert property (p_we_setup) else $error("no setup before strobe");
    property p_we_width; $fell(flash_we_n) |-> !flash_we_n [*7] ##1 flash_we_n; endproperty
    a_we_width: assert property (p_we_width) else $error("strobe width wrong");
    property p_desel; flash_ce_n |-> flash_oe_n && flash_we_n; endproperty
    a_desel: assert property (p_desel) else $error("strobe while deselected");
    property p_rd_float; !flash_oe_n |-> flash_dq_oe[14:0] == 15'h0000; endproperty
    a_rd_float: assert property (p_rd_float) else $error("host drives during read");
    property p_byte_lanes; !flash_byte_n |-> flash_dq_oe[14:8] == 7'h00; endproperty
    a_byte_lanes: assert property (p_byte_lanes) else $error("upper lanes driven");
    property p_byte_lsb; !flash_oe_n && !flash_byte_n |-> flash_dq_oe[15]; endproperty
    a_byte_lsb: assert property (p_byte_lsb) else $error("low address bit undriven");
    property p_word_lanes; flash_byte_n && !flash_we_n |-> flash_dq_oe == 16'hFFFF; endproperty
    a_word_lanes: assert property (p_word_lanes) else $error("word lanes undriven");
    property p_rd_hold; $fell(flash_oe_n) |=> (!flash_oe_n && $stable(flash_addr)) [*8];
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read cut short");
    property p_rst_width; $rose(flash_reset_n) |-> rlow_q >= 8'h64; endproperty
    a_rst_width: assert property (p_rst_width) else $error("reset pulse short");
endmodule // pfhc_ctrl_monitor

bind pfhc_ctrl pfhc_ctrl_monitor pfhc_ctrl_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n),
    .flash_byte_n(flash_byte_n));

/* dv/pfhc_flash_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Flash device model
// ------------------------------------------------------------
module pfhc_flash_model #(
    parameter logic [15:0] MFR_ID = 16'h00C3, // Arbitrary value
    parameter logic [15:0] DEV_ID = 16'h005A // Arbitrary value
) (
    // Clock
    input wire logic clk_sys,
    // Device pins
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] flash_dq_o,
    input wire logic [15:0] flash_dq_oe,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic flash_byte_n,
    // Resolved data lines
    output logic [15:0] flash_dq_i
);
    logic [15:0] mem [16];
    logic [1:0] seq;
    logic ident;
    logic flip = 1'b0;
    logic [15:0] word, val, dev_en, bus;
    // Array preload; power-up reads array
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'hA500 | 16'(i);
        seq = 2'h0;
        ident = 1'b0;
    end
    // Floating lines toggle
    always @(posedge clk_sys) flip <= ~flip;
    // Command decode
    always @(negedge flash_we_n or negedge flash_reset_n) begin
        if (!flash_reset_n) begin
            ident = 1'b0;
            seq = 2'h0;
        end else if (!flash_ce_n && flash_oe_n) begin
            if (bus[7:0] == 8'hF0) begin
                ident = 1'b0;
                seq = 2'h0;
            end else if (seq == 2'h3) begin
                mem[flash_addr[3:0]] = bus;
                seq = 2'h0;
            end else if (seq == 2'h2) begin
                ident = (bus[7:0] == 8'h90);
                seq = (bus[7:0] == 8'hA0) ? 2'h3 : 2'h0;
            end else if (seq == 2'h1) begin
                seq = (flash_addr == 21'h0002AA && bus[7:0] == 8'h55) ? 2'h2 : 2'h0;
            end else begin
                seq = (flash_addr == 21'h000555 && bus[7:0] == 8'hAA) ? 2'h1 : 2'h0;
            end
        end
    end
    // Output drive and lane steering
    assign word = ident ? (flash_addr[0] ? DEV_ID : MFR_ID) : mem[flash_addr[3:0]];
    assign val = flash_byte_n ? word : {8'h00, flash_dq_o[15] ? word[15:8] : word[7:0]};
    assign dev_en = {16{!flash_ce_n && !flash_oe_n && flash_reset_n}}
        & (flash_byte_n ? 16'hFFFF : 16'h00FF);
    assign bus = (flash_dq_oe & flash_dq_o) | (~flash_dq_oe & dev_en & val)
        | (~flash_dq_oe & ~dev_en & {8{flip, ~flip}});
    assign flash_dq_i = bus;
endmodule // pfhc_flash_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [20:0] flash_addr;
    logic [15:0] flash_dq_o, flash_dq_oe, flash_dq_i;
    logic flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_hv_reset_en;
    logic flash_byte_n, flash_wp_n;
    int miscompares = 0;
    int checks_done = 0;
    logic [31:0] rd;
    localparam logic [15:0] MFR_ID = 16'h00C3; // Arbitrary value
    localparam logic [15:0] DEV_ID = 16'h005A; // Arbitrary value
    always #2.5 clk_sys = ~clk_sys;
    pfhc_ctrl pfhc_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n),
        .flash_hv_reset_en(flash_hv_reset_en), .flash_byte_n(flash_byte_n),
        .flash_wp_n(flash_wp_n));
    pfhc_flash_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) pfhc_flash_model_i (
        .clk_sys(clk_sys), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
        .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n), .flash_byte_n(flash_byte_n),
        .flash_dq_i(flash_dq_i));
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic do_op(input logic [2:0] op);
        logic [31:0] s;
        apb(1'b1, pfhc_pkg::REG_CMD, {29'h0, op}, s);
        for (int i = 0; i < 600; i++) begin
            apb(1'b0, pfhc_pkg::REG_STATUS, 32'h0, s);
            if (s[pfhc_pkg::STAT_BUSY] === 1'b0) break;
        end
    endtask
    task automatic rd_at(input logic [31:0] a);
        apb(1'b1, pfhc_pkg::REG_ADDR, a, rd);
        do_op(pfhc_pkg::OP_READ);
        apb(1'b0, pfhc_pkg::REG_RDATA, 32'h0, rd);
    endtask
    task automatic wr_at(input logic [20:0] a, input logic [15:0] d);
        apb(1'b1, pfhc_pkg::REG_ADDR, {11'h0, a}, rd);
        apb(1'b1, pfhc_pkg::REG_WDATA, {16'h0, d}, rd);
        do_op(pfhc_pkg::OP_WRITE);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        #300000;
        miscompares++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        check("ce_n", {31'h0, flash_ce_n}, 32'h1);
        apb(1'b0, pfhc_pkg::REG_CTRL, 32'h0, rd);
        check("ctrl", rd, {27'h0, pfhc_pkg::CTRL_RESET});
        apb(1'b0, pfhc_pkg::REG_PMASK, 32'h0, rd);
        check("pmask", rd, 32'h0);
        apb(1'b0, 8'h1C, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        rd_at(32'h3);
        check("word", rd, 32'h0000_A503);
        // Program
        wr_at(pfhc_pkg::UNLOCK1_ADDR, pfhc_pkg::UNLOCK1_DATA);
        wr_at(pfhc_pkg::UNLOCK2_ADDR, pfhc_pkg::UNLOCK2_DATA);
        wr_at(pfhc_pkg::UNLOCK1_ADDR, 16'h00A0);
        wr_at(21'h000005, 16'h1234);
        rd_at(32'h5);
        check("program", rd, 32'h0000_1234);
        // Ident mode
        do_op(pfhc_pkg::OP_IDENT);
        rd_at(32'h0);
        check("maker", rd, {16'h0, MFR_ID});
        apb(1'b0, pfhc_pkg::REG_STATUS, 32'h0, rd);
        check("need_reset", {30'h0, rd[2:1]}, 32'h3);
        rd_at(32'h1);
        check("device", rd, {16'h0, DEV_ID});
        apb(1'b1, pfhc_pkg::REG_ADDR, 32'h0, rd);
        do_op(pfhc_pkg::OP_CMD_RESET);
        rd_at(32'h3);
        check("cmd_exit", rd, 32'h0000_A503);
        // Hardware reset
        do_op(pfhc_pkg::OP_IDENT);
        do_op(pfhc_pkg::OP_HW_RESET);
        rd_at(32'h3);
        check("hw_exit", rd, 32'h0000_A503);
        // Byte mode
        apb(1'b1, pfhc_pkg::REG_CTRL, 32'h3, rd);
        rd_at(32'h8000_0003);
        check("byte_hi", rd, 32'h0000_00A5);
        rd_at(32'h0000_0003);
        check("byte_lo", rd, 32'h0000_0003);
        // Protect without HV
        apb(1'b1, pfhc_pkg::REG_CTRL, 32'h2, rd);
        do_op(pfhc_pkg::OP_PROTECT);
        apb(1'b0, pfhc_pkg::REG_STATUS, 32'h0, rd);
        check("refused", {31'h0, rd[pfhc_pkg::STAT_REFUSED]}, 32'h1);
        end_of_test();
    end
endmodule // tb_top

/* inc/pfhc_pkg.sv */
package pfhc_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses of 32-bit words
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;
    localparam logic [7:0] REG_PMASK = 8'h18;

    // Control fields
    localparam int CTRL_BYTE = 0;
    localparam int CTRL_WP_N = 1;
    localparam int CTRL_BOTTOM = 2;
    localparam int CTRL_AUTO_RST = 3;
    localparam int CTRL_HV = 4;
    localparam logic [4:0] CTRL_RESET = 5'h02;

    // Status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_ID_MODE = 1;
    localparam int STAT_NEED_RST = 2;
    localparam int STAT_REFUSED = 3;

    // Address register: A-1 lane select bit
    localparam int ADDR_LSB_BIT = 31;

    // Operation codes written to the command register
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_HW_RESET = 3'h2;
    localparam logic [2:0] OP_CMD_RESET = 3'h3;
    localparam logic [2:0] OP_IDENT = 3'h4;
    localparam logic [2:0] OP_PROTECT = 3'h5;
    localparam logic [2:0] OP_UNPROTECT = 3'h6;

    // Command cycle contents
    localparam logic [20:0] UNLOCK1_ADDR = 21'h000555;
    localparam logic [20:0] UNLOCK2_ADDR = 21'h0002AA;
    localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] IDENT_DATA = 16'h0090;
    localparam logic [15:0] RESET_DATA = 16'h00F0;
    localparam int TIMEOUT_BIT = 5;

    // Group protect address pattern bits
    localparam int PAT_A6 = 6;
    localparam int PAT_A1 = 1;
    localparam logic [23:0] PMASK_ALL = 24'hFFFFFF;
    localparam logic [23:0] PMASK_RESET = 24'h000000;

    // ------------------------------------------------------------
    // Timing, 200 MHz system clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_ACC_NS = 70;
    localparam int T_WP_NS = 35;
    localparam int T_WPH_NS = 20;
    localparam int T_SETUP_NS = 5;
    localparam int T_CLEAR_PULSE_NS = 500;
    localparam int T_RECOVER_NS = 50;
    localparam int SYNC_STAGES = 3;
    localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] WP_CYC = 8'((T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] RP_CYC =
        8'((T_CLEAR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] RH_CYC = 8'((T_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] RD_WAIT_CYC = ACC_CYC + 8'(SYNC_STAGES);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WR_SET,
        ST_WR_LOW,
        ST_WR_HIGH,
        ST_RST_LOW,
        ST_RST_REC
    } pfhc_state_type;

endpackage
